// file: dv/pif_irq_tb.sv
// Purpose: Self-checking bench for the peripheral interrupt flag block
// Assumes: APB answers with a wait state; pins settle within 8 cycles
// Notes: Driver queues expected answers; a monitor compares on pready
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic srst;
  pif_pkg::pif_apb_req_t apbReq;
  pif_pkg::pif_apb_rsp_t apbRsp;
  pif_pkg::pif_evt_t evt;
  logic extPin;
  logic [7:0] pins;
  logic periphReq;
  logic irq;
  logic [32:0] expQ[$];
  int errCount;
  int checks;
  int cyc;
  int k;
  int j;
  logic [4:0] en;
  logic [4:0] rq;

  pif_irq_top pif_irq_top_i (
    .clk(clk),
    .srst(srst),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .evt(evt),
    .extPin(extPin),
    .pins(pins),
    .periphReq(periphReq),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [32:0] exp, input logic [32:0] seen);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmpLevel(input string what, input logic exp, input logic seen);
    cmp(what, {32'h0, exp}, {32'h0, seen});
  endtask

  // Monitor takes the oldest note whenever the slave answers
  always @(posedge clk) begin
    if (apbRsp.pready === 1'b1) begin
      if (expQ.size() == 0) begin
        cmp("unrequested answer", 33'h0, 33'h1);
      end else begin
        cmp("apb answer", expQ.pop_front(), {apbRsp.pslverr, apbRsp.prdata});
      end
    end
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errCount++;
      final_report();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    expQ.push_back(exp);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= w;
    apbReq.paddr <= a;
    apbReq.pwdata <= d;
    @(posedge clk);
    apbReq.penable <= 1'b1;
    @(posedge clk);
    while (apbRsp.pready !== 1'b1) begin
      @(posedge clk);
    end
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  initial begin
    srst = 1'b1;
    apbReq = '0;
    evt = '0;
    extPin = 1'b0;
    pins = 8'h00;
    void'($urandom(32'h49d2617d));
    waitc(6);
    srst <= 1'b0;
    waitc(6);
    rd(pif_pkg::OFS_ENABLE4, 32'h0);
    rd(pif_pkg::OFS_REQUEST0, 32'h0);
    rd(pif_pkg::OFS_CONTROL, 32'h2);
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
    $display("test reset values done");

    for (int i = 0; i < 5; i++) begin
      en = 5'h01 << i;
      rq = 5'($urandom()) | en;
      evt.timer5OvfReq <= rq[4];
      evt.capCompReq <= rq[3:0];
      wr(pif_pkg::OFS_ENABLE4, {$urandom() & 32'hffffffe0} | {27'h0, en});
      rd(pif_pkg::OFS_ENABLE4, {27'h0, en});
      wr(pif_pkg::OFS_CONTROL, 32'h2);
      waitc(2);
      cmpLevel("periphReq", 1'b0, periphReq);
      wr(pif_pkg::OFS_CONTROL, 32'h3);
      waitc(2);
      cmpLevel("periphReq", 1'b1, periphReq);
      evt.timer5OvfReq <= rq[4] & ~en[4];
      evt.capCompReq <= rq[3:0] & ~en[3:0];
      waitc(2);
      cmpLevel("periphReq", 1'b0, periphReq);
    end
    evt <= '0;
    wr(pif_pkg::OFS_ENABLE4, 32'h0);
    $display("test enable gating done");

    // Global and individual enables off: flag must still set
    wr(pif_pkg::OFS_CONTROL, 32'h2);
    evt.timer0Ovf <= 1'b1;
    @(posedge clk);
    evt.timer0Ovf <= 1'b0;
    waitc(3);
    cmpLevel("irq", 1'b0, irq);
    wr(pif_pkg::OFS_INT_MASK, 32'h4);
    waitc(2);
    cmpLevel("irq", 1'b1, irq);
    rd(pif_pkg::OFS_REQUEST0, 32'h20);
    wr(pif_pkg::OFS_REQUEST0, 32'hff);
    rd(pif_pkg::OFS_REQUEST0, 32'h20);
    wr(pif_pkg::OFS_REQUEST0, 32'h0);
    rd(pif_pkg::OFS_REQUEST0, 32'h0);
    wr(pif_pkg::OFS_INT_STATUS, 32'h4);
    waitc(2);
    cmpLevel("irq", 1'b0, irq);
    $display("test timer flag done");

    // Rising edge selected at reset, then falling
    for (j = 0; j < 2; j++) begin
      extPin <= 1'b1;
      waitc(8);
      rd(pif_pkg::OFS_REQUEST0, (j == 0) ? 32'h1 : 32'h0);
      extPin <= 1'b0;
      waitc(8);
      rd(pif_pkg::OFS_REQUEST0, 32'h1);
      wr(pif_pkg::OFS_REQUEST0, 32'h0);
      rd(pif_pkg::OFS_REQUEST0, 32'h0);
      wr(pif_pkg::OFS_CONTROL, 32'h0);
    end
    wr(pif_pkg::OFS_INT_STATUS, 32'h7);
    $display("test external pin done");

    k = $urandom() % 8;
    j = (k + 1) % 8;
    wr(pif_pkg::OFS_RISE_SEL, 32'h1 << k);
    wr(pif_pkg::OFS_FALL_SEL, 32'h1 << j);
    pins <= 8'((32'h1 << k) | (32'h1 << j));
    waitc(8);
    rd(pif_pkg::OFS_PORT_FLAGS, 32'h1 << k);
    rd(pif_pkg::OFS_REQUEST0, 32'h10);
    wr(pif_pkg::OFS_REQUEST0, 32'h0);
    rd(pif_pkg::OFS_REQUEST0, 32'h10);
    wr(pif_pkg::OFS_PORT_FLAGS, ~(32'h1 << k));
    rd(pif_pkg::OFS_REQUEST0, 32'h0);
    pins <= 8'h00;
    waitc(8);
    rd(pif_pkg::OFS_PORT_FLAGS, 32'h1 << j);
    rd(pif_pkg::OFS_REQUEST0, 32'h10);
    wr(pif_pkg::OFS_PORT_FLAGS, 32'h0);
    rd(pif_pkg::OFS_REQUEST0, 32'h0);
    $display("test pin change done");

    // A reset in mid-run must drop a live flag and the enable and mask settings
    wr(pif_pkg::OFS_ENABLE4, 32'h1f);
    evt.timer0Ovf <= 1'b1;
    @(posedge clk);
    evt.timer0Ovf <= 1'b0;
    srst <= 1'b1;
    waitc(6);
    srst <= 1'b0;
    waitc(6);
    rd(pif_pkg::OFS_REQUEST0, 32'h0);
    rd(pif_pkg::OFS_ENABLE4, 32'h0);
    rd(pif_pkg::OFS_INT_MASK, 32'h0);
    cmpLevel("irq", 1'b0, irq);
    $display("test mid-run reset done");
    final_report();
  end
endmodule

// file: pkg/pif_pkg.sv
// Purpose: Constants, types and register map of the peripheral interrupt flag block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Register offsets are byte addresses
// Summary of operation
// - No peripheral request reaches the core without the global peripheral enable set.
// - Timer-zero overflow sets request bit 5; it stays until software writes zero.
// - Request bit 4 is read-only: one while any per-pin change flag is set.
// - Each pin flags only edges chosen by its rise and fall select bits.
// - Flags set on their condition regardless of any enable bit.
// - Summary flag is the OR of port change flags; clearing all clears it.
// - External pin event sets request bit 0; only a software write clears it.
package pif_pkg;

  localparam int ADDR_W = 12;
  localparam int PIN_N = 8;

  localparam logic [11:0] OFS_ENABLE4 = 12'h000;
  localparam logic [11:0] OFS_REQUEST0 = 12'h004;
  localparam logic [11:0] OFS_CONTROL = 12'h008;
  localparam logic [11:0] OFS_RISE_SEL = 12'h00c;
  localparam logic [11:0] OFS_FALL_SEL = 12'h010;
  localparam logic [11:0] OFS_PORT_FLAGS = 12'h014;
  localparam logic [11:0] OFS_INT_STATUS = 12'h018;
  localparam logic [11:0] OFS_INT_MASK = 12'h01c;

  localparam int REQ_TMR0_BIT = 5;
  localparam int REQ_SUMMARY_BIT = 4;
  localparam int REQ_EXT_BIT = 0;
  localparam int CTL_GLOBAL_BIT = 0;
  localparam int CTL_EXT_RISE_BIT = 1;
  localparam int INT_EXT_BIT = 0;
  localparam int INT_CHG_BIT = 1;
  localparam int INT_TMR0_BIT = 2;

  localparam logic [4:0] EN4_RST = 5'h00;
  localparam logic [1:0] CTL_RST = 2'h2;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [2:0] INT_RST = 3'h0;

  typedef enum logic [8:0] {
    SEL_NONE = 9'h001,
    SEL_EN4 = 9'h002,
    SEL_REQ0 = 9'h004,
    SEL_CTL = 9'h008,
    SEL_RISE = 9'h010,
    SEL_FALL = 9'h020,
    SEL_FLAGS = 9'h040,
    SEL_STAT = 9'h080,
    SEL_MASK = 9'h100
  } pif_sel_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pif_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pif_apb_rsp_t;

  typedef struct packed {
    logic timer0Ovf;
    logic timer5OvfReq;
    logic [3:0] capCompReq;
  } pif_evt_t;

  typedef struct packed {
    pif_apb_rsp_t rsp;
    logic [4:0] en4;
    logic [1:0] ctl;
    logic [7:0] riseSel;
    logic [7:0] fallSel;
    logic [7:0] portFlags;
    logic tmr0Flag;
    logic extFlag;
    logic [2:0] intStatus;
    logic [2:0] intMask;
    logic irq;
    logic periphReq;
  } pif_state_t;

endpackage

// file: src/pif_irq_top.sv
// Purpose: Peripheral interrupt enable and request flags behind an APB slave
// Assumes: Event inputs share clk; pins and external line are asynchronous
// Notes: Flags clear by writing zero; status bits clear by writing one
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module pif_irq_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register bus
  input pif_pkg::pif_apb_req_t apbReq,
  output pif_pkg::pif_apb_rsp_t apbRsp,
  // Peripheral events
  input pif_pkg::pif_evt_t evt,
  // Pins
  input wire logic extPin,
  input wire logic [pif_pkg::PIN_N-1:0] pins,
  // Requests to the core
  output logic periphReq,
  output logic irq
);

  pif_pkg::pif_state_t st_r;
  pif_pkg::pif_state_t st_nxt;

  logic [pif_pkg::PIN_N-1:0] pinRise;
  logic [pif_pkg::PIN_N-1:0] pinFall;
  logic [0:0] extRise;
  logic [0:0] extFall;
  logic extEvt;
  logic [7:0] chgSet;
  logic accessPh;
  logic commit;
  pif_pkg::pif_sel_t sel;

  function automatic pif_pkg::pif_sel_t decode(input logic [11:0] addr);
    if (addr == pif_pkg::OFS_ENABLE4) begin
      decode = pif_pkg::SEL_EN4;
    end else if (addr == pif_pkg::OFS_REQUEST0) begin
      decode = pif_pkg::SEL_REQ0;
    end else if (addr == pif_pkg::OFS_CONTROL) begin
      decode = pif_pkg::SEL_CTL;
    end else if (addr == pif_pkg::OFS_RISE_SEL) begin
      decode = pif_pkg::SEL_RISE;
    end else if (addr == pif_pkg::OFS_FALL_SEL) begin
      decode = pif_pkg::SEL_FALL;
    end else if (addr == pif_pkg::OFS_PORT_FLAGS) begin
      decode = pif_pkg::SEL_FLAGS;
    end else if (addr == pif_pkg::OFS_INT_STATUS) begin
      decode = pif_pkg::SEL_STAT;
    end else if (addr == pif_pkg::OFS_INT_MASK) begin
      decode = pif_pkg::SEL_MASK;
    end else begin
      decode = pif_pkg::SEL_NONE;
    end
  endfunction

  function automatic logic [31:0] readMux(input pif_pkg::pif_state_t s,
                                          input pif_pkg::pif_sel_t rs);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (rs)
      pif_pkg::SEL_EN4: begin
        d[4:0] = s.en4;
      end
      pif_pkg::SEL_REQ0: begin
        // Unused bits stay zero
        d[pif_pkg::REQ_TMR0_BIT] = s.tmr0Flag;
        d[pif_pkg::REQ_SUMMARY_BIT] = |s.portFlags;
        d[pif_pkg::REQ_EXT_BIT] = s.extFlag;
      end
      pif_pkg::SEL_CTL: begin
        d[1:0] = s.ctl;
      end
      pif_pkg::SEL_RISE: begin
        d[7:0] = s.riseSel;
      end
      pif_pkg::SEL_FALL: begin
        d[7:0] = s.fallSel;
      end
      pif_pkg::SEL_FLAGS: begin
        d[7:0] = s.portFlags;
      end
      pif_pkg::SEL_STAT: begin
        d[2:0] = s.intStatus;
      end
      pif_pkg::SEL_MASK: begin
        d[2:0] = s.intMask;
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    readMux = d;
  endfunction

  pif_pin_sync #(.W(pif_pkg::PIN_N)) pinSync (
    .clk(clk),
    .srst(srst),
    .pinIn(pins),
    .rise(pinRise),
    .fall(pinFall)
  );

  pif_pin_sync #(.W(1)) extSync (
    .clk(clk),
    .srst(srst),
    .pinIn(extPin),
    .rise(extRise),
    .fall(extFall)
  );

  assign sel = decode(apbReq.paddr);
  assign accessPh = apbReq.psel & apbReq.penable;
  // Writes land only at the edge where pready is sampled high
  assign commit = accessPh & st_r.rsp.pready & apbReq.pwrite & ~st_r.rsp.pslverr;
  assign extEvt = st_r.ctl[pif_pkg::CTL_EXT_RISE_BIT] ? extRise[0] : extFall[0];
  assign chgSet = (pinRise & st_r.riseSel) | (pinFall & st_r.fallSel);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp.pready = accessPh & ~st_r.rsp.pready;
    if (accessPh & ~st_r.rsp.pready) begin
      st_nxt.rsp.pslverr = (sel == pif_pkg::SEL_NONE);
      st_nxt.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : readMux(st_r, sel);
    end
    if (commit) begin
      case (sel)
        pif_pkg::SEL_EN4: begin
          st_nxt.en4 = apbReq.pwdata[4:0];
        end
        pif_pkg::SEL_REQ0: begin
          // Writing zero clears; writing one leaves the flag alone
          st_nxt.tmr0Flag = st_r.tmr0Flag & apbReq.pwdata[pif_pkg::REQ_TMR0_BIT];
          st_nxt.extFlag = st_r.extFlag & apbReq.pwdata[pif_pkg::REQ_EXT_BIT];
        end
        pif_pkg::SEL_CTL: begin
          st_nxt.ctl = apbReq.pwdata[1:0];
        end
        pif_pkg::SEL_RISE: begin
          st_nxt.riseSel = apbReq.pwdata[7:0];
        end
        pif_pkg::SEL_FALL: begin
          st_nxt.fallSel = apbReq.pwdata[7:0];
        end
        pif_pkg::SEL_FLAGS: begin
          st_nxt.portFlags = st_r.portFlags & apbReq.pwdata[7:0];
        end
        pif_pkg::SEL_STAT: begin
          st_nxt.intStatus = st_r.intStatus & ~apbReq.pwdata[2:0];
        end
        pif_pkg::SEL_MASK: begin
          st_nxt.intMask = apbReq.pwdata[2:0];
        end
        default: begin
          st_nxt.intMask = st_r.intMask;
        end
      endcase
    end
    // Hardware sets come last so an event beats a same-cycle clear
    st_nxt.portFlags = st_nxt.portFlags | chgSet;
    st_nxt.tmr0Flag = st_nxt.tmr0Flag | evt.timer0Ovf;
    st_nxt.extFlag = st_nxt.extFlag | extEvt;
    st_nxt.intStatus[pif_pkg::INT_EXT_BIT] = st_nxt.intStatus[pif_pkg::INT_EXT_BIT] | extEvt;
    st_nxt.intStatus[pif_pkg::INT_CHG_BIT] = st_nxt.intStatus[pif_pkg::INT_CHG_BIT] | (|chgSet);
    st_nxt.intStatus[pif_pkg::INT_TMR0_BIT] =
      st_nxt.intStatus[pif_pkg::INT_TMR0_BIT] | evt.timer0Ovf;
    st_nxt.irq = |(st_r.intStatus & st_r.intMask);
    st_nxt.periphReq = st_r.ctl[pif_pkg::CTL_GLOBAL_BIT] &
      (|(st_r.en4 & {evt.timer5OvfReq, evt.capCompReq}));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.en4 <= pif_pkg::EN4_RST;
      st_r.ctl <= pif_pkg::CTL_RST;
      st_r.riseSel <= pif_pkg::SEL_RST;
      st_r.fallSel <= pif_pkg::SEL_RST;
      st_r.portFlags <= pif_pkg::FLAGS_RST;
      st_r.intStatus <= pif_pkg::INT_RST;
      st_r.intMask <= pif_pkg::INT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apbRsp = st_r.rsp;
  assign periphReq = st_r.periphReq;
  assign irq = st_r.irq;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic readReq0;
  logic wrReq0;
  assign readReq0 = accessPh & ~st_r.rsp.pready & ~apbReq.pwrite &
    (sel == pif_pkg::SEL_REQ0);
  assign wrReq0 = commit & (sel == pif_pkg::SEL_REQ0);

  sequence readReq0Seq;
    readReq0 ##1 st_r.rsp.pready;
  endsequence

  periph_gate_a: assert property (
    !st_r.ctl[pif_pkg::CTL_GLOBAL_BIT] |=> !periphReq)
    else $error("Peripheral request passed with global enable clear");

  enable_gate_a: assert property (
    periphReq |-> $past(|(st_r.en4 & {evt.timer5OvfReq, evt.capCompReq})))
    else $error("Peripheral request passed without its enable");

  tmr0_set_a: assert property (
    evt.timer0Ovf |=> st_r.tmr0Flag)
    else $error("Timer zero overflow did not set its flag");

  tmr0_hold_a: assert property (
    st_r.tmr0Flag && !wrReq0 |=> st_r.tmr0Flag)
    else $error("Timer zero flag dropped without a write");

  summary_or_a: assert property (
    readReq0Seq |-> apbRsp.prdata[pif_pkg::REQ_SUMMARY_BIT] == $past(|st_r.portFlags, 1))
    else $error("Summary bit differs from OR of port flags");

  edge_mask_a: assert property (
    st_r.portFlags == 8'h00 && chgSet == 8'h00 |=> st_r.portFlags == 8'h00)
    else $error("Port flag set by an unselected edge");

  unused_zero_a: assert property (
    readReq0Seq |-> apbRsp.prdata[7:6] == 2'h0 && apbRsp.prdata[3:1] == 3'h0)
    else $error("Unused request bits read nonzero");

  flag_indep_a: assert property (
    extEvt && !st_r.ctl[pif_pkg::CTL_GLOBAL_BIT] && st_r.en4 == 5'h00 |=> st_r.extFlag)
    else $error("External flag gated by an enable");

  summary_clear_a: assert property (
    st_r.portFlags != 8'h00 && !commit && chgSet == 8'h00 |=> st_r.portFlags != 8'h00)
    else $error("Port flags cleared without a write");

  ext_hold_a: assert property (
    st_r.extFlag && !wrReq0 |=> st_r.extFlag)
    else $error("External flag dropped without a write");

  irq_level_a: assert property (
    |(st_r.intStatus & st_r.intMask) |=> irq)
    else $error("Interrupt output missing for unmasked status");

  irq_drop_a: assert property (
    !(|(st_r.intStatus & st_r.intMask)) |=> !irq)
    else $error("Interrupt output high with nothing unmasked");

  // Answer timing the bus master relies on
  pready_pulse_a: assert property (
    st_r.rsp.pready |=> !st_r.rsp.pready)
    else $error("Ready held for more than one cycle");

  wait_state_a: assert property (
    accessPh && !st_r.rsp.pready |=> st_r.rsp.pready)
    else $error("Ready missing after the first access cycle");

  unmapped_err_a: assert property (
    accessPh && !st_r.rsp.pready && sel == pif_pkg::SEL_NONE |=> st_r.rsp.pslverr)
    else $error("Unmapped access answered without error");

  sequence wrEn4Seq;
    accessPh && !st_r.rsp.pready && apbReq.pwrite && sel == pif_pkg::SEL_EN4 ##1 commit;
  endsequence

  en4_write_a: assert property (
    wrEn4Seq |=> st_r.en4 == $past(apbReq.pwdata[4:0]))
    else $error("Enable register write did not land");

  periph_pass_a: assert property (
    st_r.ctl[pif_pkg::CTL_GLOBAL_BIT] &&
      |(st_r.en4 & {evt.timer5OvfReq, evt.capCompReq}) |=> periphReq)
    else $error("Enabled peripheral request was not forwarded");

  tmr0_clear_a: assert property (
    wrReq0 && !apbReq.pwdata[pif_pkg::REQ_TMR0_BIT] && !evt.timer0Ovf |=> !st_r.tmr0Flag)
    else $error("Timer zero flag survived a zero write");

  tmr0_status_a: assert property (
    evt.timer0Ovf |=> st_r.intStatus[pif_pkg::INT_TMR0_BIT])
    else $error("Timer zero overflow did not set its status bit");

  summary_ro_a: assert property (
    wrReq0 && chgSet == 8'h00 |=> st_r.portFlags == $past(st_r.portFlags))
    else $error("Request register write changed the port flags");

  sel_off_a: assert property (
    st_r.riseSel == 8'h00 && st_r.fallSel == 8'h00 && st_r.portFlags == 8'h00
      |=> st_r.portFlags == 8'h00)
    else $error("Port flag set with every edge select clear");

  flag_clear_a: assert property (
    commit && sel == pif_pkg::SEL_FLAGS && chgSet == 8'h00 |=>
      st_r.portFlags == ($past(st_r.portFlags) & $past(apbReq.pwdata[7:0])))
    else $error("Port flag write did not clear the zero bits");

  ext_set_a: assert property (
    extEvt |=> st_r.extFlag)
    else $error("External event did not set its flag");

  ext_clear_a: assert property (
    wrReq0 && !apbReq.pwdata[pif_pkg::REQ_EXT_BIT] && !extEvt |=> !st_r.extFlag)
    else $error("External flag survived a zero write");

endmodule

// file: src/pif_pin_sync.sv
// Purpose: Three-stage pin synchroniser with settled-level edge pulses
// Assumes: Pins are asynchronous to clk
// Notes: Agreement in the first four cycles after reset sets the level without an edge
`timescale 1ns/1ps
module pif_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pins
  input wire logic [W-1:0] pinIn,
  // Edge pulses
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic primed;
    logic [1:0] fill;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } pif_sync_state_t;

  pif_sync_state_t st_r;
  pif_sync_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.rise = '0;
    st_nxt.fall = '0;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
        st_nxt.rise[i] = st_r.primed & st_r.s3[i] & ~st_r.lvl[i];
        st_nxt.fall[i] = st_r.primed & ~st_r.s3[i] & st_r.lvl[i];
      end
    end
    // Reset zeros agree at once, so count four edges before trusting agreement
    st_nxt.fill = (st_r.fill == 2'h3) ? st_r.fill : st_r.fill + 2'h1;
    st_nxt.primed = st_r.primed | (st_r.fill == 2'h3);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise = st_r.rise;
  assign fall = st_r.fall;

endmodule
